// File: design/slh_byte_mem.sv
// byte wide data memory, stores commit in program order
`timescale 1ns/1ps
module slh_byte_mem import slh_pkg::*; #(
	parameter int DEPTH = SLH_MEM_DEPTH,
	parameter int AW = SLH_MEM_AW
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// store port
	input wire logic i_wr,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [SLH_SIZE_W-1:0] i_wsize,
	input wire logic [SLH_DATA_W-1:0] i_wdata,
	// load port, combinational read
	input wire logic [AW-1:0] i_raddr,
	output logic [SLH_DATA_W-1:0] o_rdata
);
	logic [7:0] mem [DEPTH];

	// bytes written low to high; a later store in a later cycle wins
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= SLH_MEM_RESET;
			end
		end else if (i_wr) begin
			for (int b = 0; b < 8; b++) begin
				if (b < int'(i_wsize)) begin
					mem[AW'(int'(i_waddr) + b)] <= i_wdata[b*8 +: 8];
				end
			end
		end
	end

	// read wraps at the top of memory, same as write
	always_comb begin
		o_rdata = '0;
		for (int b = 0; b < 8; b++) begin
			o_rdata[b*8 +: 8] = mem[AW'(int'(i_raddr) + b)];
		end
	end
endmodule // slh_byte_mem

// File: design/slh_core.sv
// hazard, load latency and speculation control for one issue slot
`timescale 1ns/1ps
module slh_core import slh_pkg::*; #(
	parameter int LOAD_LAT = SLH_LOAD_LAT_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// issue slot
	input wire logic i_valid,
	input wire slh_instr_t i_instr,
	// issue handshake
	output logic o_stall,
	output logic o_done,
	// register write back
	output logic o_wb_valid,
	output logic [SLH_REG_W-1:0] o_wb_reg,
	output logic [SLH_DATA_W-1:0] o_wb_data,
	output logic o_wb_flag,
	// check outcome and group end
	output logic o_redirect,
	output logic o_group_end
);
	logic [SLH_DATA_W-1:0] regs [SLH_NREGS];
	logic deferred_fault_flag [SLH_NREGS];
	slh_alt_entry_t advanced_load_table [SLH_NREGS];
	logic [SLH_NREGS-1:0] pend_ff;
	logic [1:0] lat_ff;
	logic [SLH_REG_W-1:0] ld_reg_ff;
	logic ld_flag_ff;
	logic [SLH_DATA_W-1:0] ld_data_ff;
	logic [SLH_DATA_W-1:0] rdata;
	logic stall_ff, done_ff, wb_valid_ff, wb_flag_ff, redirect_ff, gend_ff;
	logic [SLH_REG_W-1:0] wb_reg_ff;
	logic [SLH_DATA_W-1:0] wb_data_ff;
	logic nxt_stall, fire, ld_ret, is_ld, is_st, is_chk, is_alu;

	// true when two byte ranges share any byte
	function automatic logic overlaps(input logic [SLH_ADDR_W-1:0] a0,
		input logic [SLH_SIZE_W-1:0] s0,
		input logic [SLH_ADDR_W-1:0] a1,
		input logic [SLH_SIZE_W-1:0] s1);
		logic [SLH_ADDR_W:0] e0, e1;
		e0 = {1'b0, a0} + {{(SLH_ADDR_W-SLH_SIZE_W+1){1'b0}}, s0};
		e1 = {1'b0, a1} + {{(SLH_ADDR_W-SLH_SIZE_W+1){1'b0}}, s1};
		return ({1'b0, a0} < e1) && ({1'b0, a1} < e0);
	endfunction

	assign is_ld = i_instr.op == SLH_OP_LOAD;
	assign is_st = i_instr.op == SLH_OP_STORE;
	assign is_chk = i_instr.op == SLH_OP_CHECK;
	assign is_alu = i_instr.op == SLH_OP_ALU;
	assign ld_ret = lat_ff == 2'h1;

	// hold a reader of a pending load, or a load while another load is in flight
	// one load in flight keeps the return path single ported
	always_comb begin
		nxt_stall = 1'b0;
		if (i_valid && (pend_ff[i_instr.src] || (is_ld && lat_ff != 2'h0))) begin
			nxt_stall = 1'b1;
		end
	end
	assign fire = i_valid && !nxt_stall;

	// memory writes go in issue order, so later stores overwrite earlier
	slh_byte_mem u_mem (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_wr(fire && is_st),
		.i_waddr(i_instr.addr[SLH_MEM_AW-1:0]),
		.i_wsize(i_instr.size),
		.i_wdata(i_instr.data),
		.i_raddr(i_instr.addr[SLH_MEM_AW-1:0]),
		.o_rdata(rdata)
	);

	// load latency pipe: data captured at issue sees every earlier store
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			lat_ff <= 2'h0;
			ld_reg_ff <= '0;
			ld_flag_ff <= 1'b0;
			ld_data_ff <= '0;
		end else if (fire && is_ld) begin
			// write back is registered, so the count ends one edge early
			lat_ff <= 2'(LOAD_LAT - 1);
			ld_reg_ff <= i_instr.dst;
			// control speculative fault defers instead of trapping
			ld_flag_ff <= i_instr.fault && i_instr.ltype == SLH_LT_CTRL;
			ld_data_ff <= rdata;
		end else if (lat_ff != 2'h0) begin
			lat_ff <= lat_ff - 2'h1;
		end
	end

	// scoreboard of destinations waiting on a load
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pend_ff <= '0;
		end else begin
			if (ld_ret) begin
				pend_ff[ld_reg_ff] <= 1'b0;
			end
			if (fire && is_ld) begin
				pend_ff[i_instr.dst] <= 1'b1;
			end
		end
	end

	// register file with flag; alu results write at issue so the next
	// group reads them, the flag propagates through dependants
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			for (int i = 0; i < SLH_NREGS; i++) begin
				regs[i] <= '0;
				deferred_fault_flag[i] <= 1'b0;
			end
		end else begin
			if (ld_ret) begin
				regs[ld_reg_ff] <= ld_flag_ff ? '0 : ld_data_ff;
				deferred_fault_flag[ld_reg_ff] <= ld_flag_ff;
			end
			if (fire && is_alu) begin
				regs[i_instr.dst] <= regs[i_instr.src] + i_instr.data;
				deferred_fault_flag[i_instr.dst] <=
					deferred_fault_flag[i_instr.src];
			end
		end
	end

	// advanced load table: allocate on data speculative load, a store
	// overlapping an entry kills it; store checked first, so the store wins
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			for (int i = 0; i < SLH_NREGS; i++) begin
				advanced_load_table[i] <= '0;
			end
		end else if (fire && is_st) begin
			for (int i = 0; i < SLH_NREGS; i++) begin
				if (advanced_load_table[i].valid && overlaps(i_instr.addr,
					i_instr.size, advanced_load_table[i].addr,
					advanced_load_table[i].size)) begin
					advanced_load_table[i].valid <= 1'b0;
				end
			end
		end else if (fire && is_ld && i_instr.ltype == SLH_LT_DATA) begin
			advanced_load_table[i_instr.dst] <= '{1'b1, i_instr.addr,
				i_instr.ltype, i_instr.size};
		end
	end

	// registered outputs
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stall_ff <= 1'b0;
			done_ff <= 1'b0;
			gend_ff <= 1'b0;
			redirect_ff <= 1'b0;
		end else begin
			stall_ff <= nxt_stall;
			done_ff <= fire;
			gend_ff <= fire && i_instr.stop;
			// check fails on flagged register or missing entry
			redirect_ff <= fire && is_chk &&
				(deferred_fault_flag[i_instr.src] ||
				 !advanced_load_table[i_instr.src].valid);
		end
	end

	// write back report follows the register file update
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wb_valid_ff <= 1'b0;
			wb_reg_ff <= '0;
			wb_data_ff <= '0;
			wb_flag_ff <= 1'b0;
		end else if (ld_ret) begin
			wb_valid_ff <= 1'b1;
			wb_reg_ff <= ld_reg_ff;
			wb_data_ff <= ld_flag_ff ? '0 : ld_data_ff;
			wb_flag_ff <= ld_flag_ff;
		end else begin
			wb_valid_ff <= 1'b0;
		end
	end

	assign o_stall = stall_ff;
	assign o_done = done_ff;
	assign o_wb_valid = wb_valid_ff;
	assign o_wb_reg = wb_reg_ff;
	assign o_wb_data = wb_data_ff;
	assign o_wb_flag = wb_flag_ff;
	assign o_redirect = redirect_ff;
	assign o_group_end = gend_ff;

	// load issued at cycle 0 returns write back at cycle 2
	sequence s_ld_issue;
		fire && is_ld;
	endsequence
	chk_load_latency: assert property (@(posedge i_clk) disable iff (i_reset)
		s_ld_issue |-> ##2 o_wb_valid)
		else $error("load result not returned after two cycles");
	chk_stall_pending: assert property (@(posedge i_clk) disable iff (i_reset)
		i_valid && pend_ff[i_instr.src] |=> o_stall && !o_done)
		else $error("consumer of pending load not stalled");
	chk_defer_flag: assert property (@(posedge i_clk) disable iff (i_reset)
		(s_ld_issue and (i_instr.fault && i_instr.ltype == SLH_LT_CTRL))
		|-> ##2 o_wb_flag)
		else $error("control speculative fault not deferred");
	chk_alt_alloc: assert property (@(posedge i_clk) disable iff (i_reset)
		(s_ld_issue and (i_instr.ltype == SLH_LT_DATA))
		|=> advanced_load_table[$past(i_instr.dst)].valid)
		else $error("advanced load did not allocate an entry");
	chk_store_kill: assert property (@(posedge i_clk) disable iff (i_reset)
		fire && is_st && advanced_load_table[0].valid &&
		overlaps(i_instr.addr, i_instr.size, advanced_load_table[0].addr,
		advanced_load_table[0].size) |=> !advanced_load_table[0].valid)
		else $error("overlapping store left entry alive");
	chk_check_redir: assert property (@(posedge i_clk) disable iff (i_reset)
		fire && is_chk && !advanced_load_table[i_instr.src].valid
		|=> o_redirect)
		else $error("failed check did not redirect");
	chk_flag_redir: assert property (@(posedge i_clk) disable iff (i_reset)
		fire && is_chk && deferred_fault_flag[i_instr.src]
		|=> o_redirect)
		else $error("flagged check did not redirect");
	chk_check_pass: assert property (@(posedge i_clk) disable iff (i_reset)
		fire && is_chk && advanced_load_table[i_instr.src].valid &&
		!deferred_fault_flag[i_instr.src] |=> !o_redirect)
		else $error("passing check redirected");
	chk_flag_token: assert property (@(posedge i_clk) disable iff (i_reset)
		o_wb_valid && o_wb_flag |-> o_wb_data == '0)
		else $error("flagged write back carries data");
	chk_group_end: assert property (@(posedge i_clk) disable iff (i_reset)
		fire && i_instr.stop |=> o_group_end && o_done)
		else $error("stop did not end the group");
endmodule // slh_core

// File: design/slh_pkg.sv
// shared constants and carrier types for the speculative load hazard block
package slh_pkg;
	localparam int SLH_REG_W = 7;
	localparam int SLH_NREGS = 128;
	localparam int SLH_ADDR_W = 16;
	localparam int SLH_DATA_W = 64;
	localparam int SLH_SIZE_W = 4;
	localparam int SLH_MEM_DEPTH = 256;
	localparam int SLH_MEM_AW = 8;
	localparam int SLH_LOAD_LAT_CYC = 2;
	localparam logic [1:0] SLH_LT_NORMAL = 2'h0;
	localparam logic [1:0] SLH_LT_CTRL = 2'h1;
	localparam logic [1:0] SLH_LT_DATA = 2'h2;
	localparam logic [7:0] SLH_MEM_RESET = 8'h00;

	typedef enum logic [2:0] {
		SLH_OP_NONE,
		SLH_OP_ALU,
		SLH_OP_LOAD,
		SLH_OP_STORE,
		SLH_OP_CHECK
	} slh_op_t;

	// one instruction slot as presented by issue
	typedef struct packed {
		slh_op_t op;
		logic [1:0] ltype;
		logic fault;
		logic [SLH_REG_W-1:0] dst;
		logic [SLH_REG_W-1:0] src;
		logic [SLH_ADDR_W-1:0] addr;
		logic [SLH_SIZE_W-1:0] size;
		logic [SLH_DATA_W-1:0] data;
		logic stop;
	} slh_instr_t;

	// one entry of the advanced load table
	typedef struct packed {
		logic valid;
		logic [SLH_ADDR_W-1:0] addr;
		logic [1:0] ltype;
		logic [SLH_SIZE_W-1:0] size;
	} slh_alt_entry_t;
endpackage

// File: sim/test_spec_load_hazard_control.sv
// self-checking bench for the speculative load hazard block
`timescale 1ns/1ps
module test_spec_load_hazard_control import slh_pkg::*;;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_valid = 1'b0;
	slh_instr_t i_instr = '0;
	logic o_stall, o_done, o_wb_valid, o_wb_flag, o_redirect, o_group_end;
	logic [SLH_REG_W-1:0] o_wb_reg, wb_r;
	logic [SLH_DATA_W-1:0] o_wb_data, wb_d;
	logic wb_f;
	logic owed = 1'b0;
	logic [7:0] mem [256];
	int miscompares = 0;
	int checks = 0;
	int cyc = 0;
	int wb_cyc, rd_cnt = 0, ge_cnt = 0, tk, a, n;

	always #2.5 i_clk = ~i_clk;

	slh_core DUT (.i_clk(i_clk), .i_reset(i_reset), .i_valid(i_valid),
		.i_instr(i_instr), .o_stall(o_stall), .o_done(o_done),
		.o_wb_valid(o_wb_valid), .o_wb_reg(o_wb_reg), .o_wb_data(o_wb_data),
		.o_wb_flag(o_wb_flag), .o_redirect(o_redirect),
		.o_group_end(o_group_end));

	// pulses are captured at the edge after they appear
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (o_wb_valid) begin
			wb_cyc <= cyc;
			wb_d <= o_wb_data;
			wb_r <= o_wb_reg;
			wb_f <= o_wb_flag;
		end
		if (o_redirect) rd_cnt <= rd_cnt + 1;
		if (o_group_end) ge_cnt <= ge_cnt + 1;
		if (cyc == 4000) begin
			miscompares++;
			complete_run();
		end
	end

	task complete_run;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task check(input logic [63:0] seen, input logic [63:0] exp,
		input string what);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function slh_instr_t mk(slh_op_t op, logic [1:0] lt, logic f, int d,
		int s, int ad, int z, logic [63:0] dat, logic st);
		mk = '{op, lt, f, SLH_REG_W'(d), SLH_REG_W'(s), SLH_ADDR_W'(ad),
			SLH_SIZE_W'(z), dat, st};
	endfunction

	// eight bytes little endian, wrapping like the memory
	function logic [63:0] rd(int ad);
		int i;
		for (i = 0; i < 8; i++) rd[8*i+:8] = mem[(ad + i) % 256];
	endfunction

	// present one instruction; refuse is the expected number of stalls
	task issue(input slh_instr_t ins, input int refuse, input bit last);
		int k;
		i_valid <= 1'b1;
		i_instr <= ins;
		for (k = 0; k <= refuse; k++) begin
			@(negedge i_clk);
			check(o_done, k == 0 ? owed : 1'b0, "done");
			check(o_stall, k != 0, "stall");
			@(posedge i_clk);
		end
		tk = cyc;
		owed = 1'b1;
		if (last) i_valid <= 1'b0;
	endtask

	task idle(input int c);
		repeat (c) begin
			@(negedge i_clk);
			check(o_done, owed, "done");
			owed = 1'b0;
			@(posedge i_clk);
		end
	endtask

	task st(input int ad, input int z, input logic [63:0] d, input bit last);
		int i;
		issue(mk(SLH_OP_STORE, 0, 0, 0, 0, ad, z, d, 0), 0, last);
		for (i = 0; i < z; i++) mem[(ad + i) % 256] = d[8*i+:8];
	endtask

	task ld(input int d, input int ad, input logic [1:0] lt, input logic f);
		logic def;
		def = f && lt == SLH_LT_CTRL;
		wb_cyc = -1;
		issue(mk(SLH_OP_LOAD, lt, f, d, 0, ad, 8, 0, 0), 0, 1);
		idle(3);
		check(wb_cyc - tk, SLH_LOAD_LAT_CYC, "load latency");
		check(wb_r, d, "wb reg");
		check(wb_d, def ? 64'h0 : rd(ad), "wb data");
		check(wb_f, def, "wb flag");
	endtask

	task chk(input int s, input logic exp);
		int r;
		r = rd_cnt;
		issue(mk(SLH_OP_CHECK, 0, 0, 0, s, 0, 0, 0, 0), 0, 1);
		idle(2);
		check(rd_cnt - r, exp, "redirect");
	endtask

	initial begin
		void'($urandom(32'hc380bd03));
		for (n = 0; n < 256; n++) mem[n] = SLH_MEM_RESET;
		repeat (20) begin
			@(negedge i_clk);
			check({o_stall, o_done, o_wb_valid, o_redirect, o_group_end}, 0,
				"reset outputs");
			@(posedge i_clk);
		end
		i_reset <= 1'b0;
		@(posedge i_clk);
		// same address twice in one group, later value must win
		st(16, 8, 64'h1, 0);
		st(16, 8, 64'h2, 0);
		ld(1, 16, SLH_LT_NORMAL, 0);
		// load partly over a just written range, back to back
		st(40, 8, {$urandom, $urandom}, 0);
		ld(2, 38, SLH_LT_NORMAL, 0);
		st(254, 8, {$urandom, $urandom}, 0);
		ld(3, 252, SLH_LT_NORMAL, 0);
		// early consumer stalls, stop makes result usable next group
		n = ge_cnt;
		issue(mk(SLH_OP_LOAD, 0, 0, 5, 0, 16, 8, 0, 0), 0, 0);
		issue(mk(SLH_OP_ALU, 0, 0, 6, 5, 0, 0, 64'h3, 1), 1, 0);
		issue(mk(SLH_OP_ALU, 0, 0, 9, 6, 0, 0, 64'h1, 0), 0, 0);
		issue(mk(SLH_OP_LOAD, 0, 0, 7, 0, 16, 8, 0, 0), 0, 0);
		issue(mk(SLH_OP_LOAD, 0, 0, 8, 0, 16, 8, 0, 0), 1, 1);
		idle(3);
		check(ge_cnt - n, 1, "group end");
		// control speculation: deferred fault marks the target
		ld(20, 60, SLH_LT_CTRL, 1);
		ld(21, 60, SLH_LT_CTRL, 0);
		issue(mk(SLH_OP_ALU, 0, 0, 22, 20, 0, 0, 64'h1, 1), 0, 1);
		idle(1);
		chk(22, 1);
		chk(21, 1);
		// live table entry, so only the propagated flag can redirect
		ld(23, 80, SLH_LT_DATA, 0);
		issue(mk(SLH_OP_ALU, 0, 0, 23, 20, 0, 0, 64'h0, 1), 0, 1);
		idle(1);
		chk(23, 1);
		// data speculation: table entry survives only disjoint stores
		ld(30, 100, SLH_LT_DATA, 0);
		chk(30, 0);
		st(104, 1, 64'h5a, 0);
		chk(30, 1);
		ld(31, 120, SLH_LT_DATA, 0);
		st(119, 1, 64'h11, 0);
		st(128, 4, 64'h22, 0);
		chk(31, 0);
		st(127, 1, 64'h33, 0);
		chk(31, 1);
		ld(32, 0, SLH_LT_NORMAL, 0);
		chk(32, 1);
		// entry zero is the one the store kill assertion watches
		ld(0, 200, SLH_LT_DATA, 0);
		chk(0, 0);
		st(206, 2, 64'h77, 0);
		chk(0, 1);
		// random traffic against the byte model
		repeat (40) begin
			a = $urandom % 256;
			st(a, 1 + $urandom % 8, {$urandom, $urandom}, 0);
			ld(1 + $urandom % 127, $urandom % 256, SLH_LT_NORMAL, 0);
		end
		complete_run();
	end
endmodule // test_spec_load_hazard_control
